// ---- rtl/pllcc_top.sv ----
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "pllcc_defs.svh"

// Clock generation and low-power control. Every generated clock is an
// enable on pclk, high for one cycle per tick; the tick rate is the clock rate.
module pllcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic oscillator_bypass_n,
    input wire logic clock_source_input,
    output logic crystal_drive_output,
    input wire logic idle_req,
    input wire pllcc_pkg::pllcc_wake_t wake,
    output pllcc_pkg::pllcc_clk_en_t clk_en,
    output logic low_power_active
);

    ////////////////////////////////////////////////////////////////////
    // State and helpers.

    pllcc_pkg::pllcc_st_t s_r;
    pllcc_pkg::pllcc_st_t s_nxt;

    logic in_edge;
    logic osc_on;
    logic pll_on;
    logic t_half;
    logic t_pll;
    logic pll_raw;
    logic src_tick;
    logic sys_tick;
    logic [1:0] req_src;
    logic wake_ext;
    logic wake_now;
    logic setup_ph;
    logic access_ph;
    logic addr_ok;
    logic [16:0] acc_sum;
    logic [3:0] mult;
    logic [3:0] freq_mhz;
    logic wd_tick;
    logic a_tick;
    logic [10:0] wd_div;
    logic [10:0] a_div;

    // Multiply ratio from the three feedback divider bits.
    function automatic logic [3:0] mult_of(input logic [2:0] code);
        case (code)
            3'h0: mult_of = 4'h1;
            3'h1: mult_of = 4'h2;
            3'h2: mult_of = 4'h3;
            3'h3: mult_of = 4'h4;
            3'h4: mult_of = 4'h5;
            3'h5: mult_of = 4'h9;
            default: mult_of = 4'h1;
        endcase
    endfunction : mult_of

    // Tick of one source; both upper mode codes select the PLL.
    function automatic logic tick_of(
        input logic [1:0] sel,
        input logic th,
        input logic ti,
        input logic tp
    );
        case (sel)
            `PLLCC_SRC_HALF: tick_of = th;
            `PLLCC_SRC_IN: tick_of = ti;
            default: tick_of = tp;
        endcase
    endfunction : tick_of

    function automatic logic [1:0] src_of(input logic [1:0] mode);
        if (mode == `PLLCC_SRC_HALF || mode == `PLLCC_SRC_IN) begin
            src_of = mode;
        end else begin
            src_of = `PLLCC_SRC_PLL;
        end
    endfunction : src_of

    ////////////////////////////////////////////////////////////////////
    // Prescalers for the watchdog and analog clocks.

    assign freq_mhz = s_r.ctl1[`PLLCC_C1_FREQ];
    assign a_div = {7'h00, freq_mhz};
    assign wd_div = s_r.ctl0[`PLLCC_C0_WDPS] ?
        (11'(freq_mhz) << (`PLLCC_WD_SHIFT + 1)) :
        (11'(freq_mhz) << `PLLCC_WD_SHIFT);

    pllcc_ratediv u_wd_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick_in(in_edge),
        .divisor(wd_div),
        .tick_out(wd_tick)
    );

    pllcc_ratediv u_analog_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick_in(in_edge),
        .divisor(a_div),
        .tick_out(a_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        s_nxt = s_r;
        acc_sum = 17'h00000;
        pll_raw = 1'b0;
        sys_tick = 1'b0;
        wake_now = 1'b0;

        // Three-stage pin synchronisers; a level counts once the
        // second and third stages agree.
        s_nxt.pin_s1 = clock_source_input;
        s_nxt.pin_s2 = s_r.pin_s1;
        s_nxt.pin_s3 = s_r.pin_s2;
        if (s_r.pin_s2 == s_r.pin_s3) begin
            s_nxt.pin_f = s_r.pin_s3;
        end
        s_nxt.pin_d = s_r.pin_f;
        s_nxt.byp_s1 = oscillator_bypass_n;
        s_nxt.byp_s2 = s_r.byp_s1;
        s_nxt.byp_s3 = s_r.byp_s2;
        if (s_r.byp_s2 == s_r.byp_s3) begin
            s_nxt.byp_f = s_r.byp_s3;
        end

        // Oscillator and PLL power follow the low-power state.
        osc_on = !(s_r.pstate == pllcc_pkg::ps_stop &&
                   s_r.lp_mode == `PLLCC_PM_OSCPD);
        pll_on = osc_on && !(s_r.pstate == pllcc_pkg::ps_osc_wait) &&
                 !(s_r.pstate == pllcc_pkg::ps_stop &&
                   (s_r.lp_mode == `PLLCC_PM_PLLPD ||
                    s_r.lp_mode == `PLLCC_PM_OSCPD));

        // Crystal mode drives the inverting amplifier output; clock-in
        // mode leaves it low and takes the pin edge directly.
        s_nxt.xtal = osc_on && s_r.byp_f && !s_r.pin_f;
        in_edge = osc_on && s_r.pin_f && !s_r.pin_d;

        // Input frequency divided by two.
        if (in_edge) begin
            s_nxt.half_tog = !s_r.half_tog;
        end
        t_half = in_edge && s_r.half_tog;

        // The PLL measures the input period in pclk cycles and spreads
        // mult output ticks evenly across each input period.
        mult = mult_of(s_r.ctl1[`PLLCC_C1_MULT]);
        if (in_edge) begin
            s_nxt.period = s_r.per_cnt;
            s_nxt.per_cnt = 16'h0001;
        end else if (s_r.per_cnt != 16'hffff) begin
            s_nxt.per_cnt = s_r.per_cnt + 16'h0001;
        end
        if (!pll_on) begin
            s_nxt.locked = 1'b0;
            s_nxt.lock_cnt = 5'h00;
            s_nxt.acc = 16'h0000;
            s_nxt.pll_half = 1'b0;
        end else begin
            if (in_edge && !s_r.locked) begin
                s_nxt.lock_cnt = s_r.lock_cnt + 5'h01;
                if (s_r.lock_cnt == `PLLCC_LOCK_EDGES - 5'h01) begin
                    s_nxt.locked = 1'b1;
                end
            end
            if (s_r.locked && s_r.period != 16'h0000) begin
                acc_sum = {1'b0, s_r.acc} + 17'(mult);
                if (acc_sum >= {1'b0, s_r.period}) begin
                    pll_raw = 1'b1;
                    s_nxt.acc = 16'(acc_sum - {1'b0, s_r.period});
                end else begin
                    s_nxt.acc = acc_sum[15:0];
                end
            end
        end
        if (pll_raw) begin
            s_nxt.pll_half = !s_r.pll_half;
        end
        t_pll = pll_raw &&
                (!s_r.ctl1[`PLLCC_C1_PLLDIV2] || s_r.pll_half);

        // Synchronising switch: after a change of mode, wait for a tick
        // of the old source, then pass nothing until the first tick of
        // the new one, so no shortened period reaches the core.
        req_src = src_of(s_r.ctl0[`PLLCC_C0_MODE]);
        if (s_r.armed) begin
            src_tick = tick_of(req_src, t_half, in_edge, t_pll);
            if (src_tick) begin
                s_nxt.cur_src = req_src;
                s_nxt.armed = 1'b0;
            end
        end else begin
            src_tick = tick_of(s_r.cur_src, t_half, in_edge, t_pll);
            if (req_src != s_r.cur_src && src_tick) begin
                s_nxt.armed = 1'b1;
            end
        end

        // Peripheral prescaler; the divide choice is taken only when a
        // peripheral period ends.
        if (src_tick) begin
            if (s_r.sys_cnt == (s_r.sys_div4 ? 2'h3 : 2'h1)) begin
                s_nxt.sys_cnt = 2'h0;
                sys_tick = 1'b1;
                s_nxt.sys_div4 = s_r.ctl0[`PLLCC_C0_SYSDIV];
            end else begin
                s_nxt.sys_cnt = s_r.sys_cnt + 2'h1;
            end
        end

        // Wake sources.
        wake_ext = wake.nmi_req ||
            (wake.global_irq_en && ((wake.external_irq_one && wake.ext_irq_en[0]) ||
            (wake.external_irq_two && wake.ext_irq_en[1]) ||
            (wake.external_irq_three && wake.ext_irq_en[2])));

        // Low-power state machine.
        case (s_r.pstate)
            pllcc_pkg::ps_run: begin
                if (idle_req) begin
                    s_nxt.lp_mode = s_r.ctl0[`PLLCC_C0_PM];
                    s_nxt.pstate = pllcc_pkg::ps_stop;
                end
            end
            pllcc_pkg::ps_stop: begin
                if (s_r.lp_mode == `PLLCC_PM_IDLE1) begin
                    wake_now = wake.irq_pending || wake_ext ||
                               wake.rti_wake;
                end else begin
                    wake_now = wake_ext || (wake.rti_wake &&
                        s_r.lp_mode != `PLLCC_PM_OSCPD);
                end
                if (wake_now) begin
                    s_nxt.wait_cnt = 16'h0000;
                    if (s_r.lp_mode == `PLLCC_PM_OSCPD) begin
                        s_nxt.pstate = pllcc_pkg::ps_osc_wait;
                    end else begin
                        s_nxt.pstate = pllcc_pkg::ps_pll_wait;
                    end
                end
            end
            pllcc_pkg::ps_osc_wait: begin
                s_nxt.wait_cnt = s_r.wait_cnt + 16'h0001;
                if (s_r.wait_cnt == 16'(`PLLCC_OSC_START_CYC - 1)) begin
                    s_nxt.pstate = pllcc_pkg::ps_pll_wait;
                end
            end
            pllcc_pkg::ps_pll_wait: begin
                if (s_r.cur_src != `PLLCC_SRC_PLL || s_r.locked) begin
                    s_nxt.pstate = pllcc_pkg::ps_run;
                end
            end
            default: begin
                s_nxt.pstate = pllcc_pkg::ps_run;
            end
        endcase

        // Clock enables: core only in run; peripheral also in idle one.
        s_nxt.clk_en.core_clock = src_tick &&
            s_r.pstate == pllcc_pkg::ps_run;
        s_nxt.clk_en.peripheral_clock = sys_tick &&
            (s_r.pstate == pllcc_pkg::ps_run ||
             (s_r.pstate == pllcc_pkg::ps_stop &&
              s_r.lp_mode == `PLLCC_PM_IDLE1));
        s_nxt.clk_en.watchdog_tick_clock = wd_tick && osc_on;
        s_nxt.clk_en.analog_clock = a_tick && osc_on;

        // Register bus: read data is captured in the setup cycle so it
        // stands from a flop during the zero-wait access cycle.
        setup_ph = psel && !penable;
        access_ph = psel && penable;
        if (setup_ph && !pwrite) begin
            s_nxt.prdata = 32'h00000000;
            case (paddr)
                `PLLCC_OFF_CTL0: s_nxt.prdata[7:0] = s_r.ctl0;
                `PLLCC_OFF_CTL1: s_nxt.prdata[7:0] = s_r.ctl1;
                `PLLCC_OFF_STAT: begin
                    s_nxt.prdata[`PLLCC_ST_LOCK] = s_r.locked;
                    s_nxt.prdata[`PLLCC_ST_OSC] = osc_on;
                    s_nxt.prdata[`PLLCC_ST_SWITCH] = s_r.armed;
                    s_nxt.prdata[`PLLCC_ST_SRC] = s_r.cur_src;
                    s_nxt.prdata[`PLLCC_ST_PS] = s_r.pstate;
                    s_nxt.prdata[`PLLCC_ST_BYP] = s_r.byp_f;
                end
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end
        if (access_ph && pwrite) begin
            if (paddr == `PLLCC_OFF_CTL0) begin
                s_nxt.ctl0 = pwdata[7:0];
            end
            if (paddr == `PLLCC_OFF_CTL1) begin
                s_nxt.ctl1 = pwdata[7:0];
                // A new feedback ratio forces the PLL to relock.
                if (pwdata[`PLLCC_C1_MULT] != s_r.ctl1[`PLLCC_C1_MULT]) begin
                    s_nxt.locked = 1'b0;
                    s_nxt.lock_cnt = 5'h00;
                    s_nxt.acc = 16'h0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctl0 <= `PLLCC_CTL0_RST;
            s_r.ctl1 <= `PLLCC_CTL1_RST;
            s_r.cur_src <= `PLLCC_SRC_HALF;
            s_r.byp_f <= 1'b1;
            s_r.pstate <= pllcc_pkg::ps_run;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs.

    always_comb begin
        addr_ok = (paddr == `PLLCC_OFF_CTL0) ||
                  (paddr == `PLLCC_OFF_CTL1) ||
                  (paddr == `PLLCC_OFF_STAT);
    end

    assign pready = 1'b1;
    assign pslverr = access_ph && !addr_ok;
    assign prdata = s_r.prdata;
    assign clk_en = s_r.clk_en;
    assign crystal_drive_output = s_r.xtal;
    assign low_power_active = s_r.pstate != pllcc_pkg::ps_run;

endmodule : pllcc_top

// ---- rtl/pllcc_defs.svh ----
`ifndef PLLCC_DEFS_SVH
`define PLLCC_DEFS_SVH

`define PLLCC_CLK_PERIOD_NS 8
`define PLLCC_OSC_START_NS 1000
`define PLLCC_OSC_START_CYC \
    ((`PLLCC_OSC_START_NS + `PLLCC_CLK_PERIOD_NS - 1) / `PLLCC_CLK_PERIOD_NS)
`define PLLCC_LOCK_EDGES 5'h10

`define PLLCC_OFF_CTL0 12'h000
`define PLLCC_OFF_CTL1 12'h004
`define PLLCC_OFF_STAT 12'h008
`define PLLCC_CTL0_RST 8'h00
`define PLLCC_CTL1_RST 8'h40

`define PLLCC_C0_MODE 7:6
`define PLLCC_C0_SYSDIV 4
`define PLLCC_C0_PM 3:2
`define PLLCC_C0_WDPS 0
`define PLLCC_C1_FREQ 7:4
`define PLLCC_C1_PLLDIV2 3
`define PLLCC_C1_MULT 2:0

`define PLLCC_ST_LOCK 0
`define PLLCC_ST_OSC 1
`define PLLCC_ST_SWITCH 2
`define PLLCC_ST_SRC 4:3
`define PLLCC_ST_PS 6:5
`define PLLCC_ST_BYP 7

`define PLLCC_SRC_HALF 2'h0
`define PLLCC_SRC_IN 2'h1
`define PLLCC_SRC_PLL 2'h2

`define PLLCC_PM_IDLE1 2'h0
`define PLLCC_PM_IDLE2 2'h1
`define PLLCC_PM_PLLPD 2'h2
`define PLLCC_PM_OSCPD 2'h3

`define PLLCC_WD_SHIFT 6
`endif

// ---- rtl/pllcc_pkg.sv ----
package pllcc_pkg;

    typedef enum logic [1:0] {ps_run, ps_stop, ps_osc_wait, ps_pll_wait} pllcc_ps_t;

    typedef struct packed {
        logic core_clock;
        logic peripheral_clock;
        logic watchdog_tick_clock;
        logic analog_clock;
    } pllcc_clk_en_t;

    typedef struct packed {
        logic irq_pending;
        logic rti_wake;
        logic nmi_req;
        logic external_irq_one;
        logic external_irq_two;
        logic external_irq_three;
        logic [2:0] ext_irq_en;
        logic global_irq_en;
    } pllcc_wake_t;

    typedef struct packed {
        logic [10:0] cnt;
        logic out;
    } pllcc_div_st_t;

    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic pin_s1, pin_s2, pin_s3, pin_f, pin_d;
        logic byp_s1, byp_s2, byp_s3, byp_f;
        logic half_tog;
        logic [15:0] per_cnt;
        logic [15:0] period;
        logic [15:0] acc;
        logic [4:0] lock_cnt;
        logic locked;
        logic pll_half;
        logic [1:0] cur_src;
        logic armed;
        logic [1:0] sys_cnt;
        logic sys_div4;
        pllcc_ps_t pstate;
        logic [1:0] lp_mode;
        logic [15:0] wait_cnt;
        pllcc_clk_en_t clk_en;
        logic xtal;
        logic [31:0] prdata;
    } pllcc_st_t;

endpackage : pllcc_pkg

// ---- rtl/pllcc_ratediv.sv ----
`timescale 1ns/10ps
`include "pllcc_defs.svh"

// Emits one pulse for every divisor input ticks; divisor 0 acts as 1.
module pllcc_ratediv (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick_in,
    input wire logic [10:0] divisor,
    output logic tick_out
);

    pllcc_pkg::pllcc_div_st_t s_r;
    pllcc_pkg::pllcc_div_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.out = 1'b0;
        if (tick_in) begin
            if ({1'b0, s_r.cnt} + 12'h001 >= {1'b0, divisor}) begin
                s_nxt.cnt = 11'h000;
                s_nxt.out = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 11'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_out = s_r.out;

endmodule : pllcc_ratediv

// ---- verif/pllcc_src_model.sv ----
`timescale 1ns/10ps

// Free-running clock source seen at the input pin; it stands still only while stopped.
module pllcc_src_model (
    input wire logic pclk,
    input wire logic run,
    input wire logic [7:0] half_cyc,
    output logic src_out
);
    logic [7:0] cnt;

    initial begin
        cnt = 8'h00;
        src_out = 1'b0;
    end

    always @(posedge pclk) begin
        if (!run) begin
            cnt <= 8'h00;
        end else if (cnt + 8'h01 >= half_cyc) begin
            cnt <= 8'h00;
            src_out <= ~src_out;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : pllcc_src_model

// ---- verif/pllcc_checker_sva.sv ----
`timescale 1ns/10ps
`include "pllcc_defs.svh"

module pllcc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic oscillator_bypass_n,
    input wire logic clock_source_input,
    input wire logic crystal_drive_output,
    input wire logic idle_req,
    input wire pllcc_pkg::pllcc_wake_t wake,
    input wire pllcc_pkg::pllcc_clk_en_t clk_en,
    input wire logic low_power_active
);
    logic mapped;
    logic [1:0] pm_shadow_r;
    logic [1:0] pm_sleep_r;

    assign mapped = paddr == `PLLCC_OFF_CTL0 || paddr == `PLLCC_OFF_CTL1 ||
        paddr == `PLLCC_OFF_STAT;

    // Shadow of the power mode field, frozen when the sleep starts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_shadow_r <= 2'h0;
            pm_sleep_r <= 2'h0;
        end else begin
            if (psel && penable && pwrite && paddr == `PLLCC_OFF_CTL0) begin
                pm_shadow_r <= pwdata[`PLLCC_C0_PM];
            end
            if (idle_req && !low_power_active) begin
                pm_sleep_r <= pm_shadow_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_high: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_rdata_unmapped: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_idle_enter: assert property (idle_req && !low_power_active |=> low_power_active)
        else $error("idle request did not sleep");
    a_core_stopped: assert property (
        $past(low_power_active) && low_power_active |-> !clk_en.core_clock)
        else $error("core pulse while asleep");
    a_nmi_wake: assert property (
        low_power_active && wake.nmi_req |-> ##[1:1000] !low_power_active)
        else $error("nonmaskable wake ignored");
    a_rti_wake: assert property (
        low_power_active && wake.rti_wake && pm_sleep_r != `PLLCC_PM_OSCPD
        |-> ##[1:1000] !low_power_active)
        else $error("watchdog wake ignored");
    a_bypass_quiet: assert property ((!oscillator_bypass_n) [*6] |-> !crystal_drive_output)
        else $error("crystal driven in bypass");
    a_per_single: assert property (clk_en.peripheral_clock |=> !clk_en.peripheral_clock)
        else $error("peripheral pulse too long");
    a_wd_single: assert property (
        clk_en.watchdog_tick_clock |=> !clk_en.watchdog_tick_clock)
        else $error("watchdog pulse too long");
    a_ana_single: assert property (clk_en.analog_clock |=> !clk_en.analog_clock)
        else $error("analog pulse too long");
endmodule : pllcc_checker

bind pllcc_top pllcc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscillator_bypass_n(oscillator_bypass_n),
    .clock_source_input(clock_source_input), .crystal_drive_output(crystal_drive_output),
    .idle_req(idle_req), .wake(wake), .clk_en(clk_en), .low_power_active(low_power_active));

// ---- verif/test_pll_clock_and_low_power_control.sv ----
`timescale 1ns/10ps
`include "pllcc_defs.svh"

module test_pll_clock_and_low_power_control;
    localparam int CORE = 3;
    localparam int PER = 2;
    localparam int WD = 1;
    localparam int ANA = 0;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic oscillator_bypass_n = 1'b0;
    logic clock_source_input;
    logic crystal_drive_output;
    logic idle_req = 1'b0;
    pllcc_pkg::pllcc_wake_t wake = '0;
    pllcc_pkg::pllcc_clk_en_t clk_en;
    logic low_power_active;
    logic src_run = 1'b1;
    logic [7:0] src_half = 8'h08;
    int n_mismatch = 0;
    int check_count = 0;
    int n [4];
    int ratio [7] = '{1, 2, 3, 4, 5, 9, 2};

    always #4 pclk = ~pclk;

    pllcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oscillator_bypass_n(oscillator_bypass_n),
        .clock_source_input(clock_source_input), .crystal_drive_output(crystal_drive_output),
        .idle_req(idle_req), .wake(wake), .clk_en(clk_en), .low_power_active(low_power_active));
    pllcc_src_model u_src (.pclk(pclk), .run(src_run), .half_cyc(src_half),
        .src_out(clock_source_input));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Mismatches %0d in %0d checks", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        chk(pready, 1'b1, "bus answer");
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {24'h0, d}, q, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp, "read data");
        chk(e, err, "read error flag");
    endtask : rd

    task automatic wait_pulse(input int b, output int k);
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (clk_en[b] !== 1'b1 && k < 20000);
    endtask : wait_pulse

    // The first two pulses after a change may be irregular, so the third gap is measured.
    task automatic gap(input int b, input int exp, input string m);
        int k;
        wait_pulse(b, k);
        wait_pulse(b, k);
        wait_pulse(b, k);
        chk(k, exp, m);
    endtask : gap

    task automatic count(input int cyc);
        n = '{0, 0, 0, 0};
        repeat (cyc) begin
            @(posedge pclk);
            for (int b = 0; b < 4; b++) begin
                if (clk_en[b] === 1'b1) begin
                    n[b]++;
                end
            end
        end
    endtask : count

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic e;
        int k;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`PLLCC_OFF_CTL0, 32'h00, 1'b0);
        rd(`PLLCC_OFF_CTL1, 32'h40, 1'b0);
        gap(CORE, 32, "core at half input");
        gap(PER, 64, "peripheral at half core");
        rd(12'h00c, 32'h0, 1'b1);
        apb(1'b1, 12'h010, 32'h0, q, e);
        chk(e, 1'b1, "unmapped write error");
        apb(1'b1, `PLLCC_OFF_CTL0, 32'hffff_ff00, q, e);
        rd(`PLLCC_OFF_CTL0, 32'h00, 1'b0);
        wr(`PLLCC_OFF_CTL0, 8'h40);
        gap(CORE, 16, "core at input");
        gap(PER, 32, "peripheral at half core");
        wr(`PLLCC_OFF_CTL0, 8'h50);
        gap(PER, 64, "peripheral at quarter core");
        gap(ANA, 64, "analog at code 4");
        wr(`PLLCC_OFF_CTL1, 8'h60);
        gap(ANA, 96, "analog at code 6");
        wr(`PLLCC_OFF_CTL1, 8'h40);
        gap(WD, 4096, "watchdog");
        wr(`PLLCC_OFF_CTL0, 8'h41);
        gap(WD, 8192, "watchdog prescaled");
        wr(`PLLCC_OFF_CTL0, 8'h40);
        src_half <= 8'h0c;
        gap(CORE, 24, "core on slow source");
        src_half <= 8'h08;
        for (int i = 0; i < 7; i++) begin
            wr(`PLLCC_OFF_CTL0, i == 5 ? 8'hc0 : 8'h80);
            wr(`PLLCC_OFF_CTL1, i == 6 ? 8'h4b : 8'h40 | i[7:0]);
            repeat (300) @(posedge pclk);
            k = 0;
            do begin
                apb(1'b0, `PLLCC_OFF_STAT, 32'h0, q, e);
                k++;
            end while (q[`PLLCC_ST_LOCK] !== 1'b1 && k < 100);
            chk(q[`PLLCC_ST_SRC], `PLLCC_SRC_PLL, "pll source active");
            count(256);
            k = 16 * ratio[i];
            chk(n[CORE] >= k - 2 && n[CORE] <= k + 2, 1'b1, "pll");
        end
        oscillator_bypass_n <= 1'b1;
        repeat (16) @(posedge pclk);
        apb(1'b0, `PLLCC_OFF_STAT, 32'h0, q, e);
        chk(q[`PLLCC_ST_BYP], 1'b1, "crystal mode seen");
        q[0] = crystal_drive_output;
        repeat (8) @(posedge pclk);
        chk(crystal_drive_output ^ q[0], 1'b1, "crystal drive toggles");
        oscillator_bypass_n <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            wr(`PLLCC_OFF_CTL0, 8'h40 | (m[7:0] << 2));
            idle_req <= 1'b1;
            @(posedge pclk);
            idle_req <= 1'b0;
            @(posedge pclk);
            chk(low_power_active, 1'b1, "sleep entered");
            src_run <= m != 3;
            count(4200);
            chk(n[CORE], 0, "core stopped");
            chk(n[PER] != 0, m == 0, "peripheral in sleep");
            chk(n[WD] != 0, m != 3, "watchdog in sleep");
            if (m > 0) begin
                wake.rti_wake <= m == 3;
                wake.external_irq_one <= 1'b1;
                wake.ext_irq_en <= 3'h1;
                repeat (200) @(posedge pclk);
                chk(low_power_active, 1'b1, "unusable wake ignored");
                wake <= '0;
                @(posedge pclk);
            end
            case (m)
                0: wake.irq_pending <= 1'b1;
                1: wake.rti_wake <= 1'b1;
                2: wake <= '{external_irq_two: 1'b1, ext_irq_en: 3'h2, global_irq_en: 1'b1,
                    default: '0};
                default: wake.nmi_req <= 1'b1;
            endcase
            src_run <= 1'b1;
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (low_power_active !== 1'b0 && k < 1000);
            chk(m == 3 ? k >= 125 && k < 1000 : k <= 4, 1'b1, "wake latency");
            wake <= '0;
            gap(CORE, 16, "core after wake");
        end
        complete_run;
    end

    initial begin
        repeat (95000) @(posedge pclk);
        n_mismatch++;
        $display("BAD %0t run timed out", $time);
        complete_run;
    end
endmodule : test_pll_clock_and_low_power_control
